// ==== ddr_cmd_defs.svh ====
// constants for the command/address input side of a ddr memory module
// assumes a 100 MHz core clock and a link clock made by the controller end
// How it works
// - inputs sampled where true clock rises, complement falls
// - select, row, column, write strobes form one command
// - output drivers switch on clock crossings only
// - clock gate high wakes clock, buffers, drivers
// - gate low: idle banks power-down/refresh, open active
// - gate registered on clock for power-down, refresh entry
// - gate acts at once for refresh exit, drivers
// - controller keeps gate high through every access
// - power-down keeps only clocks and gate buffers
// - self refresh keeps only the gate buffer
// - registered high select masks the whole command
// - bank lines pick the bank of a command
// - activate carries the row address
// - read/write carry column, bit ten auto-precharge
// - precharge bit ten low one bank, high all
// - mode load carries opcode on address lines
// - mode load bank lines pick base or extended
`ifndef DDR_CMD_DEFS_SVH
`define DDR_CMD_DEFS_SVH
`define ADDR_W            12
`define BA_W              2
`define BANKS             4
`define AUTO_PRE_BIT      10
`define CODE_W            4
`define SYNC_W            21
// {select_n, ras_n, cas_n, we_n}
`define CODE_LOAD_MODE    4'h0
`define CODE_REFRESH      4'h1
`define CODE_PRECHARGE    4'h2
`define CODE_ACTIVE       4'h3
`define CODE_WRITE        4'h4
`define CODE_READ         4'h5
`define CODE_BURST_STOP   4'h6
`define CODE_NOP          4'h7
`define CODE_DESELECT     4'hf
`define CORE_CLK_NS       10
`define LINK_CK_PERIOD_NS 120
`define LINK_CK_HALF_CYC  ((`LINK_CK_PERIOD_NS / 2) / `CORE_CLK_NS)
`define ACCESS_HOLD_CK    4
`endif

// ==== ddr_cmd_pkg.sv ====
// types and command coding shared by both ends of the command link
// assumes ddr_cmd_defs.svh for widths and codes
`include "ddr_cmd_defs.svh"
package ddr_cmd_pkg;
    typedef enum logic [3:0] {
        cmd_nop        = 4'b0000,
        cmd_active     = 4'b0001,
        cmd_read       = 4'b0010,
        cmd_write      = 4'b0011,
        cmd_burst_stop = 4'b0100,
        cmd_precharge  = 4'b0101,
        cmd_refresh    = 4'b0110,
        cmd_load_mode  = 4'b0111,
        cmd_deselect   = 4'b1000
    } cmd_e;
    typedef enum logic [1:0] {
        pwr_on        = 2'b00,
        pwr_pd_idle   = 2'b01,
        pwr_pd_active = 2'b10,
        pwr_self_ref  = 2'b11
    } pwr_e;
    typedef enum logic [1:0] {
        hst_run = 2'b00,
        hst_pd  = 2'b01,
        hst_sr  = 2'b10
    } host_e;
    typedef logic [`ADDR_W-1:0] addr_t;
    typedef logic [`BA_W-1:0]   bank_t;
    typedef logic [`BANKS-1:0]  bankmask_t;
    // select high masks everything, whatever the strobes say
    function automatic cmd_e cmd_decode(input logic [`CODE_W-1:0] code);
        cmd_e c;
        c = cmd_nop;
        if (code[3]) begin
            c = cmd_deselect;
        end else begin
            case (code)
                `CODE_LOAD_MODE:  c = cmd_load_mode;
                `CODE_REFRESH:    c = cmd_refresh;
                `CODE_PRECHARGE:  c = cmd_precharge;
                `CODE_ACTIVE:     c = cmd_active;
                `CODE_WRITE:      c = cmd_write;
                `CODE_READ:       c = cmd_read;
                `CODE_BURST_STOP: c = cmd_burst_stop;
                default:          c = cmd_nop;
            endcase
        end
        return c;
    endfunction
    function automatic logic [`CODE_W-1:0] cmd_encode(input cmd_e c);
        logic [`CODE_W-1:0] code;
        code = `CODE_NOP;
        case (c)
            cmd_load_mode:  code = `CODE_LOAD_MODE;
            cmd_refresh:    code = `CODE_REFRESH;
            cmd_precharge:  code = `CODE_PRECHARGE;
            cmd_active:     code = `CODE_ACTIVE;
            cmd_write:      code = `CODE_WRITE;
            cmd_read:       code = `CODE_READ;
            cmd_burst_stop: code = `CODE_BURST_STOP;
            cmd_deselect:   code = `CODE_DESELECT;
            default:        code = `CODE_NOP;
        endcase
        return code;
    endfunction
endpackage

// ==== ddr_cmd_if.sv ====
// command/address link between controller end and module end
// the testbench instantiates it and joins the two ends
`timescale 1ns/100ps
`include "ddr_cmd_defs.svh"
interface ddr_cmd_if;
    logic                ck;              // true link clock
    logic                ck_n;            // complement link clock
    logic                module_clock_gate;
    logic                module_select_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [`BA_W-1:0]    ba;
    logic [`ADDR_W-1:0]  addr;
    logic                out_drv_en;      // module output drivers live
    modport host (
        output ck, ck_n, module_clock_gate, module_select_n,
        output ras_n, cas_n, we_n, ba, addr,
        input  out_drv_en
    );
    modport device (
        input  ck, ck_n, module_clock_gate, module_select_n,
        input  ras_n, cas_n, we_n, ba, addr,
        output out_drv_en
    );
endinterface

// ==== ddr_pin_sync.sv ====
// two-stage synchroniser for a bundle of pin inputs
// assumes pins may change at any time relative to the core clock
`timescale 1ns/100ps
module ddr_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,   // core clock
    input  wire logic         reset_in, // async, active high
    input  wire logic [W-1:0] d_in,     // raw pins
    output logic      [W-1:0] q_out     // synchronised pins
);
    logic [W-1:0] meta_ff;
    // first stage is read only by the second
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_ff <= '0;
            q_out   <= '0;
        end else begin
            meta_ff <= d_in;
            q_out   <= meta_ff;
        end
    end
endmodule

// ==== ddr_cmd_host.sv ====
// controller end: makes the link clock and drives commands
// assumes one request at a time from the user side, on the core clock
`timescale 1ns/100ps
module ddr_cmd_host
    import ddr_cmd_pkg::*;
(
    ddr_cmd_if.host              link,          // command link
    input  wire logic            core_clk_in,   // 100 MHz
    input  wire logic            reset_in,      // async, active high
    input  wire logic            req_valid_in,  // command waiting
    input  wire ddr_cmd_pkg::cmd_e req_cmd_in,  // command to send
    input  wire ddr_cmd_pkg::bank_t req_bank_in, // bank lines
    input  wire ddr_cmd_pkg::addr_t req_addr_in, // address lines
    output logic                 req_ready_out, // command taken now
    input  wire logic            pd_req_in,     // want power-down
    input  wire logic            sr_req_in,     // want self refresh
    output logic                 gate_out       // gate level driven
);
    import ddr_cmd_pkg::*;
    localparam int HALF = `LINK_CK_HALF_CYC;
    logic [7:0]          div_ff;
    logic                ck_ff;
    logic                fall;
    logic [2:0]          hold_ff;
    logic [`CODE_W-1:0]  code_ff;
    bank_t               ba_ff;
    addr_t               addr_ff;
    logic                gate_ff;
    host_e               st_ff;
    // link clock by division; pins change on its falling half
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_ff <= 8'h00;
            ck_ff  <= 1'b0;
        end else if (div_ff == 8'(HALF - 1)) begin
            div_ff <= 8'h00;
            ck_ff  <= ~ck_ff;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end
    assign fall = (div_ff == 8'(HALF - 1)) && ck_ff;
    // requests only while running, during the hold-off as well
    assign req_ready_out = fall && (st_ff == hst_run);
    // pins, gate and power state, all moved at the falling half
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            code_ff <= `CODE_NOP;
            ba_ff   <= '0;
            addr_ff <= '0;
            gate_ff <= 1'b1;
            st_ff   <= hst_run;
            hold_ff <= 3'h0;
        end else if (fall) begin
            code_ff <= `CODE_NOP;
            case (st_ff)
                hst_run: begin
                    if (req_valid_in) begin
                        code_ff <= cmd_encode(req_cmd_in);
                        ba_ff   <= req_bank_in;
                        addr_ff <= req_addr_in;
                        if (req_cmd_in == cmd_read || req_cmd_in == cmd_write) begin
                            hold_ff <= 3'(`ACCESS_HOLD_CK);
                        end
                    end else if (hold_ff != 3'h0) begin
                        hold_ff <= hold_ff - 3'h1;         // gate stays high
                    end else if (sr_req_in) begin
                        code_ff <= `CODE_REFRESH;          // refresh with gate low
                        gate_ff <= 1'b0;
                        st_ff   <= hst_sr;
                    end else if (pd_req_in) begin
                        gate_ff <= 1'b0;
                        st_ff   <= hst_pd;
                    end
                end
                hst_pd: begin
                    if (!pd_req_in) begin
                        gate_ff <= 1'b1;
                        st_ff   <= hst_run;
                    end
                end
                hst_sr: begin
                    if (!sr_req_in) begin
                        gate_ff <= 1'b1;
                        st_ff   <= hst_run;
                    end
                end
                default: st_ff <= hst_run;
            endcase
        end
    end
    assign link.ck                = ck_ff;
    assign link.ck_n              = ~ck_ff;
    assign link.module_clock_gate = gate_ff;
    assign {link.module_select_n, link.ras_n, link.cas_n, link.we_n} = code_ff;
    assign link.ba                = ba_ff;
    assign link.addr              = addr_ff;
    assign gate_out               = gate_ff;
endmodule

// ==== ddr_cmd_device.sv ====
// module end: registers commands from the link and tracks power state
// assumes the link pins are asynchronous to the core clock
`timescale 1ns/100ps
module ddr_cmd_device
    import ddr_cmd_pkg::*;
(
    ddr_cmd_if.device                link,           // command link
    input  wire logic                core_clk_in,    // 100 MHz
    input  wire logic                reset_in,       // async, active high
    output logic                     cmd_valid_out,  // one-cycle command pulse
    output ddr_cmd_pkg::cmd_e        cmd_out,        // decoded command
    output ddr_cmd_pkg::bank_t       bank_out,       // registered bank lines
    output ddr_cmd_pkg::addr_t       addr_out,       // registered address
    output logic                     auto_pre_out,   // read/write auto-precharge
    output logic                     mode_wr_out,    // one-cycle mode load pulse
    output logic                     mode_ext_out,   // extended mode register
    output ddr_cmd_pkg::addr_t       mode_opcode_out, // mode opcode
    output ddr_cmd_pkg::bankmask_t   bank_open_out,  // banks with an open row
    output ddr_cmd_pkg::pwr_e        pwr_state_out,  // power state
    output logic                     cmd_buf_en_out, // command buffers live
    output logic                     clk_buf_en_out  // clock buffers live
);
    import ddr_cmd_pkg::*;

    // synchronised pins
    logic [`SYNC_W-1:0]  pins_s;
    logic                ck_s;
    logic                ckn_s;
    logic                gate_s;
    logic [`CODE_W-1:0]  code_s;
    bank_t               ba_s;
    addr_t               addr_s;

    // crossing detection and state
    logic                ck_prev_ff;
    logic                crossing;
    logic                take;
    cmd_e                cmd_now;
    pwr_e                pwr_ff;
    pwr_e                nxt_pwr;
    bankmask_t           open_ff;
    bankmask_t           nxt_open;
    logic                drv_en_ff;
    logic                cmd_buf_en;
    logic                clk_buf_en;

    // every link input passes two flip-flops, the gate pin also feeding the drivers raw
    ddr_pin_sync #(
        .W(`SYNC_W)
    ) u_pin_sync (
        .clk_in   (core_clk_in),
        .reset_in (reset_in),
        .d_in     ({link.ck, link.ck_n, link.module_clock_gate,
                    link.module_select_n, link.ras_n, link.cas_n,
                    link.we_n, link.ba, link.addr}),
        .q_out    (pins_s)
    );
    assign {ck_s, ckn_s, gate_s, code_s, ba_s, addr_s} = pins_s;

    // buffer gating by power state
    // power-down keeps the clock pair and the gate listening
    assign cmd_buf_en = (pwr_ff == pwr_on);
    // self refresh drops the clock pair as well
    assign clk_buf_en = (pwr_ff != pwr_self_ref);
    assign cmd_buf_en_out = cmd_buf_en;
    assign clk_buf_en_out = clk_buf_en;

    // previous true-clock level for edge finding
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ck_prev_ff <= 1'b0;
        end else begin
            ck_prev_ff <= ck_s;
        end
    end

    // true clock rising while complement is low; both pins sampled
    // together, so a skewed pair yields at most one crossing
    assign crossing = clk_buf_en && ck_s && !ck_prev_ff && !ckn_s;

    // the four select/strobe levels decode as one code
    assign cmd_now = cmd_decode(code_s);

    // a command is taken only with the gate high at this crossing
    // and the command buffers awake
    assign take = crossing && gate_s && cmd_buf_en;

    // power state
    always_comb begin
        nxt_pwr = pwr_ff;
        case (pwr_ff)
            pwr_on: begin
                // gate low counts only when registered on a crossing
                if (crossing && !gate_s) begin
                    if (|open_ff) begin
                        nxt_pwr = pwr_pd_active;
                    end else if (cmd_now == cmd_refresh) begin
                        nxt_pwr = pwr_self_ref;
                    end else begin
                        nxt_pwr = pwr_pd_idle;
                    end
                end
            end
            pwr_pd_idle, pwr_pd_active: begin
                // exit also waits for a crossing with gate high
                if (crossing && gate_s) begin
                    nxt_pwr = pwr_on;
                end
            end
            pwr_self_ref: begin
                // clocks are ignored here, so exit needs no edge
                if (gate_s) begin
                    nxt_pwr = pwr_on;
                end
            end
            default: nxt_pwr = pwr_on;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pwr_ff <= pwr_on;
        end else begin
            pwr_ff <= nxt_pwr;
        end
    end
    assign pwr_state_out = pwr_ff;

    // open-row tracking per bank
    always_comb begin
        nxt_open = open_ff;
        if (take) begin
            case (cmd_now)
                cmd_active: begin
                    nxt_open[ba_s] = 1'b1;
                end
                cmd_read, cmd_write: begin
                    if (addr_s[`AUTO_PRE_BIT]) begin
                        nxt_open[ba_s] = 1'b0;
                    end
                end
                cmd_precharge: begin
                    if (addr_s[`AUTO_PRE_BIT]) begin
                        nxt_open = '0;                   // all banks
                    end else begin
                        nxt_open[ba_s] = 1'b0;           // one bank
                    end
                end
                default: nxt_open = open_ff;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            open_ff <= '0;
        end else begin
            open_ff <= nxt_open;
        end
    end
    assign bank_open_out = open_ff;

    // command register; deselect leaves every output untouched
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cmd_valid_out <= 1'b0;
            cmd_out       <= cmd_nop;
            bank_out      <= '0;
            addr_out      <= '0;
            auto_pre_out  <= 1'b0;
        end else begin
            cmd_valid_out <= take && (cmd_now != cmd_deselect);
            if (take && cmd_now != cmd_deselect) begin
                cmd_out      <= cmd_now;
                bank_out     <= ba_s;
                addr_out     <= addr_s;
                auto_pre_out <= addr_s[`AUTO_PRE_BIT] &&
                                (cmd_now == cmd_read || cmd_now == cmd_write);
            end
        end
    end

    // mode register load: opcode from address, target from bank bit 0
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_wr_out     <= 1'b0;
            mode_ext_out    <= 1'b0;
            mode_opcode_out <= '0;
        end else begin
            mode_wr_out <= take && (cmd_now == cmd_load_mode);
            if (take && cmd_now == cmd_load_mode) begin
                mode_ext_out    <= ba_s[0];
                mode_opcode_out <= addr_s;
            end
        end
    end

    // output drivers wake only on a crossing, so data leaving the
    // module stays aligned to the clock pair
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            drv_en_ff <= 1'b0;
        end else if (nxt_pwr != pwr_on) begin
            drv_en_ff <= 1'b0;
        end else if (crossing && gate_s) begin
            drv_en_ff <= 1'b1;
        end
    end

    // the raw gate pin cuts the drivers at once, with no clock;
    // the only place a pin is read without synchronising
    assign link.out_drv_en = drv_en_ff && link.module_clock_gate;
endmodule

// ==== ddr_cmd_link_assertions.sv ====
// concurrent checks on the command link between controller and module ends
// assumes one core clock domain shared by both ends and an async high reset
`timescale 1ns/100ps
`include "ddr_cmd_defs.svh"
module ddr_cmd_link_assertions (
    input  wire logic               core_clk_in,       // core clock
    input  wire logic               reset_in,          // async, active high
    input  wire logic               ck,                // true link clock
    input  wire logic               ck_n,              // complement link clock
    input  wire logic               module_clock_gate, // clock enable level
    input  wire logic               module_select_n,   // module select, low active
    input  wire logic               ras_n,             // row strobe
    input  wire logic               cas_n,             // column strobe
    input  wire logic               we_n,              // write enable
    input  wire logic [`BA_W-1:0]   ba,                // bank lines
    input  wire logic [`ADDR_W-1:0] addr,              // address lines
    input  wire logic               out_drv_en         // module drivers live
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    // command code as seen on the pins, select first
    wire [3:0] code = {module_select_n, ras_n, cas_n, we_n};

    property p_ck_pair; ck_n == ~ck; endproperty
    a_ck_pair: assert property (p_ck_pair) else $error("link clock pair not inverse");
    // high half lasts six core cycles
    property p_ck_high; $rose(ck) |-> ck [*6] ##1 !ck; endproperty
    a_ck_high: assert property (p_ck_high) else $error("link clock high half wrong");
    // whole command stands while the clock is high, so the crossing sees one code
    property p_cmd_hold; ck && $past(ck) |-> $stable(code) && $stable(ba) && $stable(addr); endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command pins moved in high half");
    // drivers drop without waiting for any edge
    property p_drv_off; !module_clock_gate |-> !out_drv_en; endproperty
    a_drv_off: assert property (p_drv_off) else $error("drivers live with gate low");
    property p_drv_on; $rose(out_drv_en) |-> module_clock_gate && ck; endproperty
    a_drv_on: assert property (p_drv_on) else $error("drivers woke off a crossing");
    property p_gate_side; $changed(module_clock_gate) |-> !ck; endproperty
    a_gate_side: assert property (p_gate_side) else $error("gate moved in high half");
    // read or write on a rising half keeps the gate up
    property p_access_gate; $rose(ck) && code[3:1] == 3'b010 |-> module_clock_gate [*8]; endproperty
    a_access_gate: assert property (p_access_gate) else $error("gate low during access");
    property p_gate_fall_code;
        $fell(module_clock_gate) |-> code == `CODE_REFRESH || code == `CODE_NOP;
    endproperty
    a_gate_fall_code: assert property (p_gate_fall_code) else $error("gate fell with bad code");
endmodule

// ==== test_ddr_module_command_input.sv ====
// self-checking bench: controller end drives the module end over the link
// assumes both ends share one 100 MHz core clock; inputs move 1 ns after edges
`timescale 1ns/100ps
module test_ddr_module_command_input;
    import ddr_cmd_pkg::*;
    logic      core_clk_in;
    logic      reset_in;
    logic      req_valid_in;
    cmd_e      req_cmd_in;
    bank_t     req_bank_in;
    addr_t     req_addr_in;
    logic      req_ready_out;
    logic      pd_req_in;
    logic      sr_req_in;
    logic      gate_out;
    logic      cmd_valid_out;
    cmd_e      cmd_out;
    bank_t     bank_out;
    addr_t     addr_out;
    logic      auto_pre_out;
    logic      mode_wr_out;
    logic      mode_ext_out;
    addr_t     mode_opcode_out;
    bankmask_t bank_open_out;
    pwr_e      pwr_state_out;
    logic      cmd_buf_en_out;
    logic      clk_buf_en_out;
    int        miscompares;
    int        checks_done;
    int        cycles;

    ddr_cmd_if link_if ();
    ddr_cmd_host ddr_cmd_host_inst (.link(link_if), .core_clk_in(core_clk_in),
        .reset_in(reset_in), .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in),
        .req_bank_in(req_bank_in), .req_addr_in(req_addr_in), .req_ready_out(req_ready_out),
        .pd_req_in(pd_req_in), .sr_req_in(sr_req_in), .gate_out(gate_out));
    ddr_cmd_device ddr_cmd_device_inst (.link(link_if), .core_clk_in(core_clk_in),
        .reset_in(reset_in), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
        .bank_out(bank_out), .addr_out(addr_out), .auto_pre_out(auto_pre_out),
        .mode_wr_out(mode_wr_out), .mode_ext_out(mode_ext_out),
        .mode_opcode_out(mode_opcode_out), .bank_open_out(bank_open_out),
        .pwr_state_out(pwr_state_out), .cmd_buf_en_out(cmd_buf_en_out),
        .clk_buf_en_out(clk_buf_en_out));
    ddr_cmd_link_assertions ddr_cmd_link_assertions_inst (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .ck(link_if.ck), .ck_n(link_if.ck_n),
        .module_clock_gate(link_if.module_clock_gate),
        .module_select_n(link_if.module_select_n), .ras_n(link_if.ras_n),
        .cas_n(link_if.cas_n), .we_n(link_if.we_n), .ba(link_if.ba), .addr(link_if.addr),
        .out_drv_en(link_if.out_drv_en));

    // core clock, 10 ns period
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // hang guard: whole run needs only a few hundred cycles
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // inputs only move just after a rising edge
    task automatic step();
        @(posedge core_clk_in);
        #1;
    endtask

    // one command through the host, judged at the device outputs
    task automatic send(input cmd_e c, input bank_t b, input addr_t a, input bankmask_t open);
        int n;
        step();
        req_cmd_in = c;
        req_bank_in = b;
        req_addr_in = a;
        req_valid_in = 1'b1;
        n = 0;
        do begin
            @(negedge core_clk_in);
            n++;
        end while (req_ready_out !== 1'b1 && n < 40);
        chk("ready", 16'h0001, {15'h0000, req_ready_out});
        step();
        req_valid_in = 1'b0;
        n = (c == cmd_deselect) ? 28 : 0; // quit before next nop
        while (cmd_valid_out !== 1'b1 && mode_wr_out !== 1'b1 && n < 40) begin
            @(negedge core_clk_in);
            n++;
        end
        if (c == cmd_deselect) begin
            chk("masked pulse", 16'h0000, {15'h0000, cmd_valid_out | mode_wr_out});
        end else if (c == cmd_load_mode) begin
            chk("mode_wr", 16'h0001, {15'h0000, mode_wr_out});
            chk("mode_ext", {15'h0000, b[0]}, {15'h0000, mode_ext_out});
            chk("opcode", {4'h0, a}, {4'h0, mode_opcode_out});
        end else begin
            chk("cmd", {12'h000, c}, {12'h000, cmd_out});
            chk("bank", {14'h0000, b}, {14'h0000, bank_out});
            chk("addr", {4'h0, a}, {4'h0, addr_out});
            chk("auto_pre", {15'h0000, (c == cmd_read || c == cmd_write) && a[10]},
                {15'h0000, auto_pre_out});
        end
        chk("bank_open", {12'h000, open}, {12'h000, bank_open_out});
        @(negedge core_clk_in);
        chk("drv_en", 16'h0001, {15'h0000, link_if.out_drv_en});
    endtask

    task automatic wait_pwr(input pwr_e s);
        int n;
        n = 0;
        while (pwr_state_out !== s && n < 300) begin
            @(negedge core_clk_in);
            n++;
        end
        chk("pwr", {14'h0000, s}, {14'h0000, pwr_state_out});
    endtask

    task automatic t_cmds();
        send(cmd_active, 2'h2, 12'h0abc, 4'b0100);
        send(cmd_active, 2'h1, 12'h0fff, 4'b0110);
        send(cmd_read, 2'h2, 12'h0400, 4'b0010);
        send(cmd_write, 2'h1, 12'h0123, 4'b0010);
        send(cmd_precharge, 2'h1, 12'h0000, 4'b0000);
        send(cmd_active, 2'h0, 12'h0001, 4'b0001);
        send(cmd_active, 2'h3, 12'h0002, 4'b1001);
        send(cmd_precharge, 2'h3, 12'h0000, 4'b0001);
        send(cmd_active, 2'h2, 12'h0800, 4'b0101);
        send(cmd_precharge, 2'h0, 12'h0400, 4'b0000);
        send(cmd_load_mode, 2'h1, 12'h0031, 4'b0000);
        send(cmd_load_mode, 2'h0, 12'h0062, 4'b0000);
        send(cmd_refresh, 2'h0, 12'h0000, 4'b0000);
        send(cmd_burst_stop, 2'h0, 12'h0000, 4'b0000);
        send(cmd_nop, 2'h0, 12'h0000, 4'b0000);
        send(cmd_deselect, 2'h3, 12'h0fff, 4'b0000);
        $display("test cmds done");
    endtask

    // power-down with a row open, then with all banks idle
    task automatic t_pd();
        send(cmd_active, 2'h1, 12'h0010, 4'b0010);
        step();
        pd_req_in = 1'b1;
        wait_pwr(pwr_pd_active);
        chk("gate", 16'h0000, {15'h0000, gate_out});
        chk("cmd_buf", 16'h0000, {15'h0000, cmd_buf_en_out});
        chk("clk_buf", 16'h0001, {15'h0000, clk_buf_en_out});
        chk("drv_off", 16'h0000, {15'h0000, link_if.out_drv_en});
        step();
        pd_req_in = 1'b0;
        wait_pwr(pwr_on);
        chk("cmd_buf", 16'h0001, {15'h0000, cmd_buf_en_out});
        send(cmd_precharge, 2'h0, 12'h0400, 4'b0000);
        step();
        pd_req_in = 1'b1;
        wait_pwr(pwr_pd_idle);
        step();
        pd_req_in = 1'b0;
        wait_pwr(pwr_on);
        $display("test power-down done");
    endtask

    // self refresh shuts even the clock buffers; gate alone wakes it
    task automatic t_sr();
        step();
        sr_req_in = 1'b1;
        wait_pwr(pwr_self_ref);
        chk("clk_buf", 16'h0000, {15'h0000, clk_buf_en_out});
        chk("cmd_buf", 16'h0000, {15'h0000, cmd_buf_en_out});
        step();
        sr_req_in = 1'b0;
        wait_pwr(pwr_on);
        send(cmd_active, 2'h3, 12'h0555, 4'b1000);
        $display("test self refresh done");
    endtask

    initial begin
        miscompares = 0;
        checks_done = 0;
        cycles = 0;
        reset_in = 1'b1;
        req_valid_in = 1'b0;
        req_cmd_in = cmd_nop;
        req_bank_in = 2'h0;
        req_addr_in = 12'h000;
        pd_req_in = 1'b0;
        sr_req_in = 1'b0;
        repeat (20) @(posedge core_clk_in);
        #1;
        reset_in = 1'b0;
        t_cmds();
        t_pd();
        t_sr();
        close_out();
    end
endmodule
